// ==== logic/sffr_top.v ====
// Serial flash fast read front end, device side
`include "sffr_map.vh"

// Operation
// - Opcode 0Bh, 24-bit address, eight dummy clocks, then single-line data out.
// - Opcode 3Bh, address, eight dummy clocks, data two bits per clock.
// - Opcode 6Bh, address, eight dummy clocks, data four bits per clock.
// - Quad output read accepted only while quad_enable_bit is one.
// - Opcode BBh takes address on two lanes and returns data on two.
// - Capture continuous_read_bits after address; lower four bits ignored.
// - continuous_read_select of binary 10 lets next transaction start at address.
// - Any other continuous_read_select means next transaction expects an opcode.
// - FFh or FFFFh mode reset clears stored continuous_read_bits.
// - Opcode EBh uses four lanes and four dummy clocks.
// - Quad address-input read accepted only with quad_enable_bit set; only EBh is checked, continuous-mode reads are not.
// - Quad address-input read honours continuous mode, omitting EBh.
// - With wrap on, quad I/O reads wrap within selected section until CS rises.
// - Wrap setting applies to all later quad I/O reads until changed.
// - wrap_disable_bit of zero enables wrapping, wrap_length_field picks the section length.
// - Opcode 77h, 24 dummy bits, then eight-bit wrap byte.
// - wrap_disable_bit resets to one; lengths 8, 16, 32, 64 bytes.
// - Inputs sampled on rising clock edge, data out on falling, MSB first.
module sffr_top #(
    parameter AW = 24
) (
    // Clock and reset
    input  wire          I_REF_CLK,
    input  wire          I_RST_N,
    // Serial link
    input  wire          I_CS_N,
    input  wire          I_SCLK,
    input  wire [3:0]    I_IO,
    output wire [3:0]    O_IO,
    output wire [3:0]    O_IO_OE_N,
    // Memory array
    output wire [AW-1:0] O_MEM_ADDR,
    output wire          O_MEM_RD,
    input  wire [7:0]    I_MEM_DATA,
    // Register port
    input  wire [3:0]    I_REG_ADDR,
    input  wire [31:0]   I_REG_WDATA,
    input  wire          I_REG_WR,
    input  wire          I_REG_RD,
    output wire [31:0]   O_REG_RDATA
);

    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam [6:0] ST_IDLE  = 7'h01;
    localparam [6:0] ST_CMD   = 7'h02;
    localparam [6:0] ST_ADDR  = 7'h04;
    localparam [6:0] ST_MODE  = 7'h08;
    localparam [6:0] ST_DUMMY = 7'h10;
    localparam [6:0] ST_DATA  = 7'h20;
    localparam [6:0] ST_SKIP  = 7'h40;

    reg  [6:0]    state_r;
    reg  [7:0]    cmd_r;
    reg  [2:0]    in_w_r;
    reg  [2:0]    out_w_r;
    reg  [3:0]    dummy_r;
    reg           has_mode_r;
    reg  [5:0]    cnt_r;
    reg  [31:0]   sh_in_r;
    reg  [7:0]    sh_out_r;
    reg  [3:0]    bit_r;
    reg  [AW-1:0] addr_r;
    reg  [7:0]    data_r;
    reg           fetch_r;
    reg           fetch_d_r;
    reg  [AW-1:0] mem_addr_r;
    reg  [7:0]    mode_bits_r;
    reg           cont_r;
    reg  [2:0]    wrap_r;
    reg           qe_r;
    reg  [3:0]    io_r;
    reg  [3:0]    oe_n_r;
    reg  [31:0]   rdata_r;
    reg           sclk_d_r;
    reg           cs_n_d_r;

    wire          rise = I_SCLK & ~sclk_d_r;
    wire          fall = ~I_SCLK & sclk_d_r;
    wire          cs_fall = ~I_CS_N & cs_n_d_r;

    // ----------------------------------------
    // Input shifting and address stepping
    // ----------------------------------------
    reg  [31:0]   sh_in_nxt;
    reg  [5:0]    cnt_nxt;
    reg  [AW-1:0] addr_nxt;
    reg  [7:0]    wrap_mask;

    always @* begin
        // Higher lane carries the more significant bit
        case (in_w_r)
            3'h4:    sh_in_nxt = {sh_in_r[27:0], I_IO[3:0]};
            3'h2:    sh_in_nxt = {sh_in_r[29:0], I_IO[1:0]};
            default: sh_in_nxt = {sh_in_r[30:0], I_IO[0]};
        endcase
        cnt_nxt = cnt_r + {3'h0, in_w_r};
        case (wrap_r[2:`SFFR_WRAP_LEN_LSB])
            2'h0:    wrap_mask = 8'h07;
            2'h1:    wrap_mask = 8'h0F;
            2'h2:    wrap_mask = 8'h1F;
            default: wrap_mask = 8'h3F;
        endcase
        if (cmd_r == `SFFR_OP_QUAD_IO && !wrap_r[`SFFR_WRAP_DIS_POS]) begin
            addr_nxt = {addr_r[AW-1:8],
                        (addr_r[7:0] & ~wrap_mask) | ((addr_r[7:0] + 8'h01) & wrap_mask)};
        end else begin
            addr_nxt = addr_r + {{(AW-1){1'b0}}, 1'b1};
        end
    end

    // ----------------------------------------
    // Transaction engine
    // ----------------------------------------
    always @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            state_r     <= ST_IDLE;
            cmd_r       <= 8'h00;
            in_w_r      <= 3'h1;
            out_w_r     <= 3'h1;
            dummy_r     <= 4'h0;
            has_mode_r  <= 1'b0;
            cnt_r       <= 6'h00;
            sh_in_r     <= 32'h00000000;
            sh_out_r    <= 8'h00;
            bit_r       <= 4'h0;
            addr_r      <= {AW{1'b0}};
            data_r      <= 8'h00;
            fetch_r     <= 1'b0;
            fetch_d_r   <= 1'b0;
            mem_addr_r  <= {AW{1'b0}};
            mode_bits_r <= `SFFR_MODE_RST_VAL;
            cont_r      <= 1'b0;
            wrap_r      <= `SFFR_WRAP_RST;
            io_r        <= 4'h0;
            oe_n_r      <= 4'hF;
            sclk_d_r    <= 1'b0;
            cs_n_d_r    <= 1'b1;
        end else begin
            sclk_d_r  <= I_SCLK;
            cs_n_d_r  <= I_CS_N;
            fetch_r   <= 1'b0;
            fetch_d_r <= fetch_r;
            if (fetch_d_r) begin
                data_r <= I_MEM_DATA;
            end
            if (I_CS_N) begin
                // Chip select high ends any transfer and frees the lanes
                state_r <= ST_IDLE;
                oe_n_r  <= 4'hF;
            end else if (cs_fall) begin
                cnt_r   <= 6'h00;
                bit_r   <= 4'h0;
                sh_in_r <= 32'h00000000;
                if (cont_r) begin
                    // same for the quad address-input read
                    state_r <= ST_ADDR;
                end else begin
                    state_r <= ST_CMD;
                    in_w_r  <= 3'h1;
                end
            end else begin
                case (state_r)
                    ST_CMD: begin
                        if (rise) begin
                            sh_in_r <= sh_in_nxt;
                            cnt_r   <= cnt_nxt;
                            if (cnt_nxt == 6'h08) begin
                                cnt_r      <= 6'h00;
                                cmd_r      <= sh_in_nxt[7:0];
                                state_r    <= ST_ADDR;
                                has_mode_r <= 1'b0;
                                dummy_r    <= `SFFR_DUMMY_OUT;
                                in_w_r     <= 3'h1;
                                case (sh_in_nxt[7:0])
                                    `SFFR_OP_FAST_RD: out_w_r <= 3'h1;
                                    `SFFR_OP_DUAL_OUT: out_w_r <= 3'h2;
                                    `SFFR_OP_QUAD_OUT: begin
                                        out_w_r <= 3'h4;
                                        if (!qe_r) begin
                                            state_r <= ST_SKIP;
                                        end
                                    end
                                    `SFFR_OP_DUAL_IO: begin
                                        in_w_r     <= 3'h2;
                                        out_w_r    <= 3'h2;
                                        has_mode_r <= 1'b1;
                                        dummy_r    <= `SFFR_DUMMY_NONE;
                                    end
                                    `SFFR_OP_QUAD_IO: begin
                                        in_w_r     <= 3'h4;
                                        out_w_r    <= 3'h4;
                                        has_mode_r <= 1'b1;
                                        dummy_r    <= `SFFR_DUMMY_QIO;
                                        if (!qe_r) begin
                                            state_r <= ST_SKIP;
                                        end
                                    end
                                    `SFFR_OP_SET_WRAP: in_w_r <= 3'h4;
                                    `SFFR_OP_MODE_RST: begin
                                        mode_bits_r <= `SFFR_MODE_RST_VAL;
                                        cont_r      <= 1'b0;
                                        state_r     <= ST_SKIP;
                                    end
                                    default: state_r <= ST_SKIP;
                                endcase
                            end
                        end
                    end
                    ST_ADDR: begin
                        if (rise) begin
                            sh_in_r <= sh_in_nxt;
                            cnt_r   <= cnt_nxt;
                            if (cmd_r == `SFFR_OP_SET_WRAP) begin
                                if (cnt_nxt == `SFFR_WRAP_BITS) begin
                                    wrap_r  <= sh_in_nxt[6:4];
                                    state_r <= ST_SKIP;
                                end
                            end else if (cnt_nxt == `SFFR_ADDR_BITS) begin
                                cnt_r      <= 6'h00;
                                addr_r     <= sh_in_nxt[AW-1:0];
                                mem_addr_r <= sh_in_nxt[AW-1:0];
                                fetch_r    <= 1'b1;
                                if (has_mode_r) begin
                                    state_r <= ST_MODE;
                                end else begin
                                    state_r <= ST_DUMMY;
                                end
                            end
                        end
                    end
                    ST_MODE: begin
                        // same lane width as the address
                        if (rise) begin
                            sh_in_r <= sh_in_nxt;
                            cnt_r   <= cnt_nxt;
                            if (cnt_nxt == `SFFR_MODE_BITS) begin
                                cnt_r       <= 6'h00;
                                mode_bits_r <= (sh_in_nxt[7:4] == 4'hF) ? `SFFR_MODE_RST_VAL
                                                                        : {sh_in_nxt[7:4], 4'h0};
                                cont_r      <= (sh_in_nxt[5:4] == `SFFR_CONT_SEL);
                                if (dummy_r == `SFFR_DUMMY_NONE) begin
                                    state_r <= ST_DATA;
                                end else begin
                                    state_r <= ST_DUMMY;
                                end
                            end
                        end
                    end
                    ST_DUMMY: begin
                        if (rise) begin
                            cnt_r <= cnt_r + 6'h01;
                            if (cnt_r + 6'h01 == {2'h0, dummy_r}) begin
                                state_r <= ST_DATA;
                            end
                        end
                    end
                    ST_DATA: begin
                        // shift out on the falling edge, MSB first
                        if (fall) begin
                            case (out_w_r)
                                3'h4: begin
                                    oe_n_r <= 4'h0;
                                    if (bit_r == 4'h0) begin
                                        io_r     <= data_r[7:4];
                                        sh_out_r <= {data_r[3:0], 4'h0};
                                    end else begin
                                        io_r     <= sh_out_r[7:4];
                                        sh_out_r <= {sh_out_r[3:0], 4'h0};
                                    end
                                end
                                3'h2: begin
                                    oe_n_r <= 4'hC;
                                    if (bit_r == 4'h0) begin
                                        io_r     <= {2'h0, data_r[7:6]};
                                        sh_out_r <= {data_r[5:0], 2'h0};
                                    end else begin
                                        io_r     <= {2'h0, sh_out_r[7:6]};
                                        sh_out_r <= {sh_out_r[5:0], 2'h0};
                                    end
                                end
                                default: begin
                                    // Single-line data leaves on io_lane1
                                    oe_n_r <= 4'hD;
                                    if (bit_r == 4'h0) begin
                                        io_r     <= {2'h0, data_r[7], 1'b0};
                                        sh_out_r <= {data_r[6:0], 1'b0};
                                    end else begin
                                        io_r     <= {2'h0, sh_out_r[7], 1'b0};
                                        sh_out_r <= {sh_out_r[6:0], 1'b0};
                                    end
                                end
                            endcase
                            if (bit_r + {1'b0, out_w_r} == 4'h8) begin
                                // Prefetch the next byte well before its first edge
                                bit_r      <= 4'h0;
                                addr_r     <= addr_nxt;
                                mem_addr_r <= addr_nxt;
                                fetch_r    <= 1'b1;
                            end else begin
                                bit_r <= bit_r + {1'b0, out_w_r};
                            end
                        end
                    end
                    default: state_r <= state_r;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    always @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            qe_r    <= `SFFR_QE_RST;
            rdata_r <= 32'h00000000;
        end else begin
            if (I_REG_WR && I_REG_ADDR == `SFFR_REG_CTRL) begin
                qe_r <= I_REG_WDATA[`SFFR_CTRL_QE_POS];
            end
            rdata_r <= 32'h00000000;
            if (I_REG_RD) begin
                if (I_REG_ADDR == `SFFR_REG_CTRL) begin
                    rdata_r <= {30'h0, qe_r, 1'b0};
                end else if (I_REG_ADDR == `SFFR_REG_STAT) begin
                    rdata_r <= {14'h0, ~I_CS_N, cont_r, mode_bits_r, 5'h00, wrap_r};
                end
            end
        end
    end

    assign O_IO        = io_r;
    assign O_IO_OE_N   = oe_n_r;
    assign O_MEM_ADDR  = mem_addr_r;
    assign O_MEM_RD    = fetch_r;
    assign O_REG_RDATA = rdata_r;

endmodule

// ==== shared/sffr_map.vh ====
// Constants for the serial flash fast read front end
`ifndef SFFR_MAP_VH
`define SFFR_MAP_VH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define SFFR_OP_FAST_RD     8'h0B
`define SFFR_OP_DUAL_OUT    8'h3B
`define SFFR_OP_QUAD_OUT    8'h6B
`define SFFR_OP_DUAL_IO     8'hBB
`define SFFR_OP_QUAD_IO     8'hEB
`define SFFR_OP_SET_WRAP    8'h77
`define SFFR_OP_MODE_RST    8'hFF

// ----------------------------------------
// Phase lengths
// ----------------------------------------
`define SFFR_ADDR_BITS      6'h18
`define SFFR_MODE_BITS      6'h08
`define SFFR_WRAP_BITS      6'h20
`define SFFR_DUMMY_OUT      4'h8
`define SFFR_DUMMY_QIO      4'h4
`define SFFR_DUMMY_NONE     4'h0
`define SFFR_CONT_SEL       2'h2

// ----------------------------------------
// Wrap setting fields and reset values
// ----------------------------------------
`define SFFR_WRAP_DIS_POS   0
`define SFFR_WRAP_LEN_LSB   1
`define SFFR_WRAP_RST       3'h1
`define SFFR_MODE_RST_VAL   8'h00

// ----------------------------------------
// Register port offsets and fields
// ----------------------------------------
`define SFFR_REG_CTRL       4'h0
`define SFFR_REG_STAT       4'h4
`define SFFR_CTRL_QE_POS    1
`define SFFR_CTRL_RST       32'h00000000
`define SFFR_QE_RST         1'b0

`endif

// ==== verif/sffr_assertions.sv ====
// Port-level checks for the fast read front end
`include "sffr_map.vh"
module sffr_assertions (
    input wire logic        I_REF_CLK,
    input wire logic        I_RST_N,
    input wire logic        I_CS_N,
    input wire logic        I_SCLK,
    input wire logic [3:0]  O_IO,
    input wire logic [3:0]  O_IO_OE_N,
    input wire logic        O_MEM_RD,
    input wire logic [3:0]  I_REG_ADDR,
    input wire logic [31:0] I_REG_WDATA,
    input wire logic        I_REG_WR,
    input wire logic        I_REG_RD,
    input wire logic [31:0] O_REG_RDATA
);
    timeunit 1ns;
    timeprecision 1ps;
    logic qe_r;
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_N);
    // Shadow of quad enable, so quad drive can be tied to it
    always @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            qe_r <= 1'b0;
        end else if (I_REG_WR && I_REG_ADDR == `SFFR_REG_CTRL) begin
            qe_r <= I_REG_WDATA[`SFFR_CTRL_QE_POS];
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    chk_oe_width: assert property (
        O_IO_OE_N inside {4'hF, 4'hD, 4'hC, 4'h0})
        else $error("output enable pattern illegal");
    chk_idle_released: assert property (
        $past(I_CS_N, 2) && $past(I_CS_N) && I_CS_N |-> O_IO_OE_N == 4'hF)
        else $error("lanes driven outside a frame");
    chk_quad_gated: assert property (
        O_IO_OE_N == 4'h0 |-> qe_r)
        else $error("quad drive without quad enable");
    chk_mem_pulse: assert property (
        O_MEM_RD |=> !O_MEM_RD)
        else $error("array read longer than one cycle");
    chk_mem_in_frame: assert property (
        O_MEM_RD |-> !$past(I_CS_N))
        else $error("array read outside a frame");
    chk_io_on_fall: assert property (
        !I_CS_N && !$past(I_CS_N) && O_IO_OE_N != 4'hF && $changed(O_IO) |-> !I_SCLK)
        else $error("output changed while serial clock high");
    chk_drive_on_fall: assert property (
        $fell(O_IO_OE_N[1]) |-> !I_SCLK && !I_CS_N)
        else $error("drive began off a falling clock");
    chk_rdata_idle: assert property (
        !$past(I_REG_RD) |-> O_REG_RDATA == 32'h0)
        else $error("read data outside its cycle");
    chk_ctrl_read: assert property (
        I_REG_RD && I_REG_ADDR == `SFFR_REG_CTRL |=> O_REG_RDATA == {30'h0, qe_r, 1'b0})
        else $error("control read mismatch");
endmodule

// ==== verif/sffr_host.sv ====
// Host controller model driving flash read frames
module sffr_host (
    input  wire logic       clk,
    input  wire logic [3:0] lanes,
    output logic            cs_n,
    output logic            sclk,
    output logic [3:0]      io_o,
    output logic [3:0]      oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        io_o = 4'h0;
        oe_n = 4'hF;
    end
    task automatic begin_cs();
        @(posedge clk);
        cs_n <= 1'b0;
    endtask
    // Clock idles low between frames
    task automatic end_cs();
        @(posedge clk);
        cs_n <= 1'b1;
        sclk <= 1'b0;
        oe_n <= 4'hF;
        repeat (4) @(posedge clk);
    endtask
    // MSB first, w lanes, taken on rise
    // drv low releases all lanes, output values ignored
    task automatic xfer(input logic [31:0] dout, input int nclk, input int w,
                        input bit drv, output logic [31:0] din);
        din = 32'h0;
        for (int i = nclk - 1; i >= 0; i--) begin
            @(posedge clk);
            sclk <= 1'b0;
            io_o <= 4'(dout >> (i * w));
            oe_n <= drv ? ~(4'hF >> (4 - w)) : 4'hF;
            repeat (3) @(posedge clk);
            din = (din << w) | (w == 1 ? 32'(lanes[1]) : 32'(lanes & (4'hF >> (4 - w))));
            sclk <= 1'b1;
            repeat (3) @(posedge clk);
        end
    endtask
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the fast read front end
`include "sffr_map.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        tog_r = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  mem_data = 8'h00;
    logic [31:0] d;
    wire         cs_n, sclk, mem_rd;
    wire  [3:0]  h_io, h_oe_n, dev_io, dev_oe_n, lanes;
    wire  [23:0] mem_addr;
    wire  [31:0] rdata;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    // Released lanes toggle so a stale value never looks valid
    assign lanes = (~h_oe_n & h_io) | (h_oe_n & ~dev_oe_n & dev_io)
                 | (h_oe_n & dev_oe_n & {4{tog_r}});
    sffr_host i_sffr_host (.clk(clk), .lanes(lanes), .cs_n(cs_n), .sclk(sclk),
                           .io_o(h_io), .oe_n(h_oe_n));
    sffr_top i_sffr_top (
        .I_REF_CLK(clk), .I_RST_N(rst_n), .I_CS_N(cs_n), .I_SCLK(sclk), .I_IO(lanes),
        .O_IO(dev_io), .O_IO_OE_N(dev_oe_n), .O_MEM_ADDR(mem_addr), .O_MEM_RD(mem_rd),
        .I_MEM_DATA(mem_data), .I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata),
        .I_REG_WR(reg_wr), .I_REG_RD(reg_rd), .O_REG_RDATA(rdata));
    always #2 clk = ~clk;
    function automatic logic [7:0] mem_byte(input logic [23:0] a);
        return a[7:0] + a[15:8] + a[23:16] + 8'h3C;
    endfunction
    always @(posedge clk) begin
        tog_r <= ~tog_r;
        if (mem_rd) mem_data <= mem_byte(mem_addr);
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        v = rdata;
    endtask
    task automatic send(input logic [31:0] v, input int n, input int w);
        i_sffr_host.xfer(v, n, w, 1'b1, d);
    endtask
    task automatic rd_chk(input logic [23:0] a, input int nb, input int w,
                          input logic [23:0] sec);
        logic [23:0] p;
        p = a;
        for (int b = 0; b < nb; b++) begin
            i_sffr_host.xfer(32'h0, 8 / w, w, 1'b0, d);
            chk(d, 32'(mem_byte(p)), "read byte");
            p = (p & ~sec) | ((p + 24'h1) & sec);
        end
    endtask
    task automatic out_read(input logic [7:0] op, input logic [23:0] a, input int w,
                            input int nb);
        i_sffr_host.begin_cs();
        send(op, 8, 1);
        send(a, 24, 1);
        i_sffr_host.xfer(32'h0, `SFFR_DUMMY_OUT, 1, 1'b0, d);
        rd_chk(a, nb, w, 24'hFFFFFF);
    endtask
    task automatic qio(input bit op, input logic [23:0] a, input logic [7:0] m,
                       input logic [23:0] sec);
        i_sffr_host.begin_cs();
        if (op) send(`SFFR_OP_QUAD_IO, 8, 1);
        send({a, m}, 8, 4);
        i_sffr_host.xfer(32'h0, `SFFR_DUMMY_QIO, 4, 1'b0, d);
        rd_chk(a, 4, 4, sec);
    endtask
    task automatic set_wrap(input logic [7:0] w);
        i_sffr_host.begin_cs();
        send(`SFFR_OP_SET_WRAP, 8, 1);
        send({24'h0, w}, 8, 4);
        i_sffr_host.end_cs();
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        reg_read(`SFFR_REG_CTRL, d);
        chk(d, 32'h0, "ctrl reset");
        reg_read(`SFFR_REG_STAT, d);
        chk(d, 32'h1, "stat reset");
        reg_write(4'h8, 32'hFFFFFFFF);
        reg_read(4'h8, d);
        chk(d, 32'h0, "unmapped read");
        @(posedge clk);
        chk(rdata, 32'h0, "read data lingers");
        $display("register test done");
    endtask
    task automatic t_out_reads();
        out_read(`SFFR_OP_FAST_RD, 24'h00FFFE, 1, 3);
        chk(dev_oe_n, 4'hD, "single lane enable");
        i_sffr_host.end_cs();
        out_read(`SFFR_OP_DUAL_OUT, 24'h0000F0, 2, 2);
        chk(dev_oe_n, 4'hC, "dual lane enable");
        i_sffr_host.end_cs();
        i_sffr_host.begin_cs();
        send(`SFFR_OP_QUAD_OUT, 8, 1);
        send(32'h000040, 24, 1);
        i_sffr_host.xfer(32'h0, 12, 4, 1'b0, d);
        chk(dev_oe_n, 4'hF, "quad read without enable");
        i_sffr_host.end_cs();
        reg_write(`SFFR_REG_CTRL, 32'h2);
        reg_read(`SFFR_REG_CTRL, d);
        chk(d, 32'h2, "ctrl quad enable");
        out_read(`SFFR_OP_QUAD_OUT, 24'h000040, 4, 2);
        chk(dev_oe_n, 4'h0, "quad lane enable");
        i_sffr_host.end_cs();
        $display("output read test done");
    endtask
    task automatic t_dual_io();
        i_sffr_host.begin_cs();
        send(`SFFR_OP_DUAL_IO, 8, 1);
        send({24'h000123, 8'h2F}, 16, 2);
        rd_chk(24'h000123, 2, 2, 24'hFFFFFF);
        i_sffr_host.end_cs();
        reg_read(`SFFR_REG_STAT, d);
        chk(32'(d[16:8]), 32'h120, "mode armed");
        i_sffr_host.begin_cs();
        send({24'h000200, 8'h20}, 16, 2);
        rd_chk(24'h000200, 1, 2, 24'hFFFFFF);
        i_sffr_host.end_cs();
        i_sffr_host.begin_cs();
        send(32'hFFFFFFFF, 16, 2);
        i_sffr_host.end_cs();
        reg_read(`SFFR_REG_STAT, d);
        chk(32'(d[16:8]), 32'h0, "mode cleared");
        $display("dual io test done");
    endtask
    task automatic t_quad_io();
        set_wrap(8'h00);
        reg_read(`SFFR_REG_STAT, d);
        chk(32'(d[2:0]), 32'h0, "wrap setting");
        qio(1'b1, 24'h000106, 8'hA0, 24'h000007);
        chk(dev_oe_n, 4'h0, "quad io enable");
        i_sffr_host.end_cs();
        qio(1'b0, 24'h000206, 8'h30, 24'h000007);
        i_sffr_host.end_cs();
        i_sffr_host.begin_cs();
        send(`SFFR_OP_MODE_RST, 8, 1);
        i_sffr_host.end_cs();
        reg_read(`SFFR_REG_STAT, d);
        chk(32'(d[16:8]), 32'h0, "mode reset opcode");
        set_wrap(8'h20);
        qio(1'b1, 24'h00011E, 8'h00, 24'h00000F);
        i_sffr_host.end_cs();
        set_wrap(8'h40);
        qio(1'b1, 24'h00015E, 8'h00, 24'h00001F);
        i_sffr_host.end_cs();
        set_wrap(8'h60);
        qio(1'b1, 24'h00013E, 8'h00, 24'h00003F);
        i_sffr_host.end_cs();
        set_wrap(8'h10);
        qio(1'b1, 24'h0001FE, 8'h00, 24'hFFFFFF);
        i_sffr_host.end_cs();
        reg_write(`SFFR_REG_CTRL, 32'h0);
        i_sffr_host.begin_cs();
        send(`SFFR_OP_QUAD_IO, 8, 1);
        send(32'h00010000, 8, 4);
        i_sffr_host.xfer(32'h0, 8, 4, 1'b0, d);
        chk(dev_oe_n, 4'hF, "quad io without enable");
        i_sffr_host.end_cs();
        $display("quad io test done");
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            $display("unexpected at %0t: run did not finish", $time);
            complete_run();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_out_reads();
        t_dual_io();
        t_quad_io();
        complete_run();
    end
endmodule
bind sffr_top sffr_assertions i_sffr_assertions (
    .I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .I_CS_N(I_CS_N), .I_SCLK(I_SCLK),
    .O_IO(O_IO), .O_IO_OE_N(O_IO_OE_N), .O_MEM_RD(O_MEM_RD), .I_REG_ADDR(I_REG_ADDR),
    .I_REG_WDATA(I_REG_WDATA), .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD),
    .O_REG_RDATA(O_REG_RDATA));
